// ==== core/iio_unit.sv ====
// Immediate I/O access unit: live input reads and direct output writes
`timescale 1ns/1ns
`include "iio_params.svh"
module iio_unit import iio_pkg::*; #(
  parameter int NPTS = `IIO_NUM_POINTS,
  parameter int AW = `IIO_POINT_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  // Sequencer side
  input wire logic scan_start,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire iio_op_t cmd_op,
  input wire logic [AW-1:0] cmd_point,
  input wire logic [AW-1:0] cmd_last,
  input wire logic [`IIO_COUNT_W-1:0] cmd_count,
  input wire logic [`IIO_WORD_ADDR_W-1:0] cmd_word,
  input wire logic cmd_rung,
  input wire logic [`IIO_ACC_W-1:0] cmd_acc,
  output logic done,
  output logic res_rung_q,
  output logic [`IIO_ACC_W-1:0] res_acc_q,
  output logic res_acc_we_q,
  output logic res_err_q,
  // I/O module side
  input wire logic [NPTS-1:0] in_pins,
  output logic [NPTS-1:0] out_pins,
  output logic [NPTS-1:0] out_image
);

  // Sequencer states
  typedef enum logic [1:0] {
    IIO_ST_IDLE,
    IIO_ST_EXEC,
    IIO_ST_ANSWER
  } iio_state_t;

  iio_state_t state_q; // Current state
  iio_state_t state_d; // Next state

  // Captured command
  iio_op_t op_q; // Operation
  logic [AW-1:0] point_q; // First point
  logic [AW-1:0] last_q; // Last point of a range
  logic [`IIO_COUNT_W-1:0] count_q; // Field bit count
  logic [`IIO_WORD_ADDR_W-1:0] word_q; // Word address
  logic rung_q; // Rung result at issue
  logic [`IIO_ACC_W-1:0] acc_q; // Accumulator at issue

  // Output state
  logic [NPTS-1:0] out_q; // Physical output points
  logic [NPTS-1:0] out_d; // Next physical output points
  logic [NPTS-1:0] img_q; // Output image register
  logic [NPTS-1:0] ored_q; // Points written by an ORed output this scan
  logic [NPTS-1:0] ored_d; // Next ORed-this-scan flags

  // Live inputs after synchronisation
  logic [NPTS-1:0] in_live;

  // Results computed in the execute cycle
  logic rung_d; // Next rung result
  logic [`IIO_ACC_W-1:0] acc_d; // Next accumulator
  logic acc_we_d; // Accumulator is written
  logic err_d; // Command refused

  // Decoding wires
  // Request taken at this edge
  wire accept = cmd_valid && cmd_ready;
  // Execute cycle: the only cycle in which outputs and results move
  wire exec = (state_q == IIO_ST_EXEC);
  // One-hot select of the addressed point
  wire [NPTS-1:0] point_bit = NPTS'(1) << point_q;
  // Live level of the addressed input, two flip-flops behind the pin
  wire live_bit = in_live[point_q];
  // Field counts of zero or above the accumulator width are refused
  wire count_ok = (count_q >= `IIO_COUNT_MIN) && (count_q <= `IIO_COUNT_MAX);
  // A range must not run backwards
  wire range_ok = (last_q >= point_q);
  // Only word addresses that map onto the local inputs
  wire word_ok = (word_q >= `IIO_WORD_FIRST) && (word_q <= `IIO_WORD_LAST);
  // Word number within the local inputs
  wire [`IIO_WORD_ADDR_W-1:0] word_idx = word_q - `IIO_WORD_FIRST;
  // Low bits kept by a formatted instruction
  wire [`IIO_ACC_W-1:0] low_mask = iio_low_mask(count_q);
  // Accumulator cut to the field width
  wire [`IIO_ACC_W-1:0] acc_field = acc_q & low_mask;

  // Last point of a formatted field, held at the top point
  wire [AW:0] field_end = {1'b0, point_q} + {{(AW + 1 - `IIO_COUNT_W){1'b0}}, count_q}
    - {{AW{1'b0}}, 1'b1};
  wire field_fits = (field_end < (AW + 1)'(NPTS));
  wire [AW-1:0] field_hi = field_fits ? field_end[AW-1:0] : AW'(NPTS - 1);
  wire is_latch = (op_q == IIO_OP_LATCH_ON) || (op_q == IIO_OP_LATCH_OFF);
  wire [AW-1:0] mask_hi = is_latch ? last_q : field_hi;
  wire [NPTS-1:0] span_mask;

  // Accumulator field placed at the first point
  wire [NPTS-1:0] field_bits = NPTS'(acc_field) << point_q;
  // Live inputs shifted so the first point lands at bit 0
  wire [NPTS-1:0] in_shift = in_live >> point_q;
  // Sixteen live inputs at the addressed word
  wire [`IIO_WORD_W-1:0] in_word = in_live[word_idx[4:0] * `IIO_WORD_W +: `IIO_WORD_W];

  // Input points cross into this clock through two flip-flops
  iio_in_sync #(
    .WIDTH(NPTS)
  ) u_in_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(in_pins),
    .sync_out(in_live)
  );

  // Span of points touched by a range or field instruction
  iio_range_mask #(
    .NPTS(NPTS),
    .AW(AW)
  ) u_span (
    .lo(point_q),
    .hi(mask_hi),
    .mask(span_mask)
  );

  // One command at a time: ready only while idle
  assign cmd_ready = (state_q == IIO_ST_IDLE);
  assign done = (state_q == IIO_ST_ANSWER);
  assign out_pins = out_q;
  assign out_image = img_q;

  // State sequencing: take, execute, answer
  always_comb begin
    case (state_q)
      IIO_ST_IDLE: begin
        state_d = accept ? IIO_ST_EXEC : IIO_ST_IDLE;
      end
      IIO_ST_EXEC: begin
        state_d = IIO_ST_ANSWER;
      end
      IIO_ST_ANSWER: begin
        state_d = IIO_ST_IDLE; // Next command only after this answer
      end
      default: begin
        state_d = IIO_ST_IDLE;
      end
    endcase
  end

  // Instruction execution against live inputs and output points
  always_comb begin
    // Defaults hold state, clear the strobes, and clear the ORed flags at scan start; only the execute cycle moves outputs
    out_d = out_q;
    ored_d = scan_start ? '0 : ored_q;
    rung_d = rung_q;
    acc_d = acc_q;
    acc_we_d = 1'b0;
    err_d = 1'b0;
    if (exec) begin
      case (op_q)
        IIO_OP_INV_CONTACT: begin
          // Live level read; no input image is written
          rung_d = rung_q & ~live_bit;
        end
        IIO_OP_OUT: begin
          // Every execution drives the point, even repeated ones
          out_d = (out_q & ~point_bit) | (rung_q ? point_bit : '0);
        end
        IIO_OP_OR_OUT: begin
          // First ORed rung of the scan sets the value, later rungs OR
          if (ored_q[point_q] && !scan_start) begin
            out_d = out_q | (rung_q ? point_bit : '0);
          end else begin
            out_d = (out_q & ~point_bit) | (rung_q ? point_bit : '0);
          end
          ored_d = ored_d | point_bit;
        end
        IIO_OP_FMT_OUT: begin
          if (count_ok) begin
            out_d = (out_q & ~span_mask) | (field_bits & span_mask);
            acc_d = acc_field;
            acc_we_d = 1'b1;
          end else begin
            // Refused count: points and accumulator untouched
            err_d = 1'b1;
          end
        end
        IIO_OP_LATCH_ON: begin
          if (range_ok) begin
            out_d = out_q | span_mask;
          end else begin
            // Backwards range refused; no point moves
            err_d = 1'b1;
          end
        end
        IIO_OP_LATCH_OFF: begin
          if (range_ok) begin
            out_d = out_q & ~span_mask;
          end else begin
            // Backwards range refused; no point moves
            err_d = 1'b1;
          end
        end
        IIO_OP_WORD_LOAD: begin
          if (word_ok) begin
            acc_d = {{(`IIO_ACC_W - `IIO_WORD_W){1'b0}}, in_word};
            acc_we_d = 1'b1;
          end else begin
            err_d = 1'b1; // Address outside the local inputs
          end
        end
        IIO_OP_FIELD_LOAD: begin
          if (count_ok) begin
            // Points beyond the top read as off; bits above count cleared
            acc_d = in_shift[`IIO_ACC_W-1:0] & low_mask;
            acc_we_d = 1'b1;
          end else begin
            // Refused count: accumulator left as issued
            err_d = 1'b1;
          end
        end
        default: begin
          // Unknown operation code answers with a refusal
          err_d = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= IIO_ST_IDLE;
    end else begin
      // Leaves idle only on a taken request; execute and answer never stall
      state_q <= state_d;
    end
  end

  // Command capture when a request is taken
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      op_q <= IIO_OP_INV_CONTACT;
      point_q <= '0;
      last_q <= '0;
      count_q <= '0;
      word_q <= '0;
      rung_q <= 1'b0;
      acc_q <= `IIO_ACC_RESET;
    end else if (accept) begin
      // Held through execute, so a dropped request cannot disturb it
      op_q <= cmd_op;
      point_q <= cmd_point;
      last_q <= cmd_last;
      count_q <= cmd_count;
      word_q <= cmd_word;
      rung_q <= cmd_rung;
      acc_q <= cmd_acc;
    end
  end

  // Physical points and image move together; latched values persist
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      out_q <= {NPTS{`IIO_OUT_RESET}};
      img_q <= {NPTS{`IIO_OUT_RESET}};
      ored_q <= '0;
    end else begin
      // Image takes the same next value, so it never lags the pins
      out_q <= out_d;
      img_q <= out_d;
      ored_q <= ored_d;
    end
  end

  // Results held from the execute cycle through the answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      res_rung_q <= 1'b0;
      res_acc_q <= `IIO_ACC_RESET;
      res_acc_we_q <= 1'b0;
      res_err_q <= 1'b0;
    end else if (exec) begin
      // Captured once per instruction; held until the next execute
      res_rung_q <= rung_d;
      res_acc_q <= acc_d;
      res_acc_we_q <= acc_we_d;
      res_err_q <= err_d;
    end
  end

endmodule // iio_unit

// ==== core/iio_params.svh ====
// Constants of the immediate I/O access unit: widths, limits and address ranges
`ifndef IIO_PARAMS_SVH
`define IIO_PARAMS_SVH

// Number of discrete points on each side (octal 0..777)
`define IIO_NUM_POINTS 512
// Width of a point address
`define IIO_POINT_W 9
// Width of the accumulator
`define IIO_ACC_W 32
// Width of a field bit count (1..32)
`define IIO_COUNT_W 6
// Least and greatest legal field bit count
`define IIO_COUNT_MIN 6'h01
`define IIO_COUNT_MAX 6'h20
// Width of a word address
`define IIO_WORD_ADDR_W 15
// Word addresses that map to local input points (octal 40400..40437)
`define IIO_WORD_FIRST 15'h4100
`define IIO_WORD_LAST 15'h411f
// Width of one loaded word
`define IIO_WORD_W 16
// Accumulator reset value
`define IIO_ACC_RESET 32'h0000_0000
// Output point reset value (all off)
`define IIO_OUT_RESET 1'b0

`endif

// ==== core/iio_pkg.sv ====
// Types and shared helpers of the immediate I/O access unit
package iio_pkg;

  // Immediate instruction selected by the sequencer
  typedef enum logic [2:0] {
    IIO_OP_INV_CONTACT,   // inverted_live_series_contact
    IIO_OP_OUT,           // direct_output_write
    IIO_OP_OR_OUT,        // ored_direct_output_write
    IIO_OP_FMT_OUT,       // formatted_direct_output
    IIO_OP_LATCH_ON,      // direct_output_latch_on
    IIO_OP_LATCH_OFF,     // direct_output_latch_off
    IIO_OP_WORD_LOAD,     // live_input_word_load
    IIO_OP_FIELD_LOAD     // live_input_field_load
  } iio_op_t;

  // Mask with the low 'count' bits set, count 0..32
  function automatic logic [31:0] iio_low_mask(input logic [5:0] count);
    logic [32:0] ones;
    ones = (33'h1 << count) - 33'h1;
    return ones[31:0];
  endfunction

endpackage

// ==== core/iio_in_sync.sv ====
// Two-stage synchroniser for the live input points
`timescale 1ns/1ns
module iio_in_sync #(
  parameter int WIDTH = 512
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // First stage, read only by the second

  // Both stages clear to off under reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // iio_in_sync

// ==== core/iio_range_mask.sv ====
// Point mask with every bit from lo to hi inclusive set
`timescale 1ns/1ns
module iio_range_mask #(
  parameter int NPTS = 512,
  parameter int AW = 9
) (
  input wire logic [AW-1:0] lo,
  input wire logic [AW-1:0] hi,
  output logic [NPTS-1:0] mask
);
  // One comparator pair per point
  for (genvar i = 0; i < NPTS; i++) begin : g_pt
    assign mask[i] = (AW'(i) >= lo) && (AW'(i) <= hi);
  end
endmodule // iio_range_mask

// ==== testbench/iio_io_model.sv ====
// Behavioural model of the local discrete input points
`timescale 1ns/1ns
module iio_io_model #(
  parameter int NPTS = 512
) (
  input wire logic clk_sys,
  input wire logic [NPTS-1:0] pattern,
  output logic [NPTS-1:0] in_pins
);
  // Field levels change just after a clock edge, like real wiring seen late
  always_ff @(posedge clk_sys) begin
    in_pins <= pattern;
  end
endmodule // iio_io_model

// ==== testbench/iio_unit_properties.sv ====
// Assertion checker for the immediate I/O access unit
`timescale 1ns/1ns
`include "iio_params.svh"
module iio_chk import iio_pkg::*; #(
  parameter int NPTS = 512,
  parameter int AW = 9
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire iio_op_t cmd_op,
  input wire logic [AW-1:0] cmd_point,
  input wire logic [AW-1:0] cmd_last,
  input wire logic [`IIO_COUNT_W-1:0] cmd_count,
  input wire logic [`IIO_WORD_ADDR_W-1:0] cmd_word,
  input wire logic cmd_rung,
  input wire logic done,
  input wire logic res_rung_q,
  input wire logic [`IIO_ACC_W-1:0] res_acc_q,
  input wire logic res_acc_we_q,
  input wire logic res_err_q,
  input wire logic [NPTS-1:0] in_pins,
  input wire logic [NPTS-1:0] out_pins,
  input wire logic [NPTS-1:0] out_image
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Request accepted at this edge
  wire take = cmd_valid && cmd_ready;
  // Pin levels one edge back: what the synchroniser hands to the execute cycle
  logic [NPTS-1:0] pins_d1;
  always_ff @(posedge clk_sys) begin
    pins_d1 <= in_pins;
  end
  // Fixed answer two edges after the take
  property p_answer; take |=> !cmd_ready ##1 done; endproperty
  // Inverted contact uses the live level
  property p_inv;
    logic r, b;
    (take && cmd_op == IIO_OP_INV_CONTACT, r = cmd_rung, b = pins_d1[cmd_point])
      |-> ##2 res_rung_q == (r && !b);
  endproperty
  // Direct write lands on the addressed point
  property p_out;
    logic r;
    logic [AW-1:0] p;
    (take && cmd_op == IIO_OP_OUT, r = cmd_rung, p = cmd_point) |-> ##2 out_pins[p] == r;
  endproperty
  property p_image; out_image == out_pins; endproperty
  // Range ends turn on or off
  property p_on;
    logic [AW-1:0] p, l;
    (take && cmd_op == IIO_OP_LATCH_ON && cmd_last >= cmd_point, p = cmd_point, l = cmd_last)
      |-> ##2 out_pins[p] && out_pins[l];
  endproperty
  property p_off;
    logic [AW-1:0] p, l;
    (take && cmd_op == IIO_OP_LATCH_OFF && cmd_last >= cmd_point, p = cmd_point, l = cmd_last)
      |-> ##2 !out_pins[p] && !out_pins[l];
  endproperty
  // Outputs move only with an answer
  property p_hold; $changed(out_pins) |-> done; endproperty
  // Field results carry nothing above the count
  property p_field;
    logic [5:0] c;
    (take && cmd_op inside {IIO_OP_FMT_OUT, IIO_OP_FIELD_LOAD} && cmd_count inside {[1:32]},
      c = cmd_count) |-> ##2 res_acc_we_q && (res_acc_q >> c) == 32'h0;
  endproperty
  property p_word;
    (take && cmd_op == IIO_OP_WORD_LOAD && !(cmd_word inside {[15'h4100:15'h411f]}))
      |-> ##2 res_err_q && !res_acc_we_q;
  endproperty
  a_answer: assert property (p_answer) else $error("answer timing wrong");
  a_inv: assert property (p_inv) else $error("inverted contact wrong");
  a_out: assert property (p_out) else $error("direct write wrong");
  a_image: assert property (p_image) else $error("image differs from pins");
  a_on: assert property (p_on) else $error("range not set");
  a_off: assert property (p_off) else $error("range not cleared");
  a_hold: assert property (p_hold) else $error("output moved idle");
  a_field: assert property (p_field) else $error("high bits not cleared");
  a_word: assert property (p_word) else $error("bad word address taken");
  c_or: cover property (take && cmd_op == IIO_OP_OR_OUT);
  c_off: cover property (take && cmd_op == IIO_OP_LATCH_OFF);
  c_err: cover property (done && res_err_q);
endmodule // iio_chk
bind iio_unit iio_chk #(.NPTS(NPTS), .AW(AW)) u_chk (.clk_sys, .resetn, .cmd_valid, .cmd_ready,
  .cmd_op, .cmd_point, .cmd_last, .cmd_count, .cmd_word, .cmd_rung, .done, .res_rung_q,
  .res_acc_q, .res_acc_we_q, .res_err_q, .in_pins, .out_pins, .out_image);

// ==== testbench/immediate_io_access_unit_bench.sv ====
// Self-checking testbench of the immediate I/O access unit
`timescale 1ns/1ns
module immediate_io_access_unit_bench;
  import iio_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic scan_start = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rung = 1'b0;
  iio_op_t cmd_op = IIO_OP_OUT;
  logic [8:0] cmd_point = 9'h0;
  logic [8:0] cmd_last = 9'h0;
  logic [5:0] cmd_count = 6'h1;
  logic [14:0] cmd_word = 15'h0;
  logic [31:0] cmd_acc = 32'h0;
  logic [31:0] res_acc_q;
  logic [511:0] pattern = '0;
  logic [511:0] in_pins, out_pins, out_image;
  logic cmd_ready, done, res_rung_q, res_acc_we_q, res_err_q;
  int num_errors = 0;
  int cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  // Field points and the unit under test
  iio_io_model #(.NPTS(512)) io (.clk_sys(clk_sys), .pattern(pattern), .in_pins(in_pins));
  iio_unit uut (.clk_sys, .resetn, .scan_start, .cmd_valid, .cmd_ready, .cmd_op, .cmd_point,
    .cmd_last, .cmd_count, .cmd_word, .cmd_rung, .cmd_acc, .done, .res_rung_q, .res_acc_q,
    .res_acc_we_q, .res_err_q, .in_pins, .out_pins, .out_image);
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One request held until taken, then the answer checked
  task automatic run(input iio_op_t op, input logic [8:0] pt, input logic [8:0] la,
      input logic [5:0] cn, input logic [14:0] wd, input logic r, input logic [31:0] a);
    int n;
    n = 0;
    cmd_op = op;
    cmd_point = pt;
    cmd_last = la;
    cmd_count = cn;
    cmd_word = wd;
    cmd_rung = r;
    cmd_acc = a;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    @(posedge clk_sys);
    #1 chk(done, 1'b1);
  endtask
  // Let new input levels pass the synchroniser
  task automatic settle(input logic [511:0] p);
    pattern = p;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  // Pulse the start of a scan
  task automatic new_scan;
    scan_start = 1'b1;
    @(posedge clk_sys);
    #1 scan_start = 1'b0;
  endtask
  task automatic t_inv;
    settle(512'h20);
    run(IIO_OP_INV_CONTACT, 9'h5, 9'h0, 6'h1, 15'h0, 1'b1, 32'h0);
    chk(res_rung_q, 1'b0);
    run(IIO_OP_INV_CONTACT, 9'h6, 9'h0, 6'h1, 15'h0, 1'b1, 32'h0);
    chk(res_rung_q, 1'b1);
    run(IIO_OP_INV_CONTACT, 9'h6, 9'h0, 6'h1, 15'h0, 1'b0, 32'h0);
    chk(res_rung_q, 1'b0);
  endtask
  task automatic t_out;
    run(IIO_OP_OUT, 9'h2, 9'h0, 6'h1, 15'h0, 1'b1, 32'h0);
    chk(out_image[2], 1'b1);
    run(IIO_OP_OUT, 9'h2, 9'h0, 6'h1, 15'h0, 1'b0, 32'h0);
    chk(out_pins[2], 1'b0);
    new_scan();
    run(IIO_OP_OR_OUT, 9'h7, 9'h0, 6'h1, 15'h0, 1'b1, 32'h0);
    run(IIO_OP_OR_OUT, 9'h7, 9'h0, 6'h1, 15'h0, 1'b0, 32'h0);
    chk(out_pins[7], 1'b1);
    new_scan();
    run(IIO_OP_OR_OUT, 9'h7, 9'h0, 6'h1, 15'h0, 1'b0, 32'h0);
    chk(out_pins[7], 1'b0);
  endtask
  task automatic t_fmt;
    run(IIO_OP_FMT_OUT, 9'h1e, 9'h0, 6'h8, 15'h0, 1'b1, 32'hdeadbe5a);
    chk(out_pins[37:30], 8'h5a);
    chk(res_acc_q, 32'h5a);
    run(IIO_OP_FMT_OUT, 9'h1f4, 9'h0, 6'h20, 15'h0, 1'b1, 32'hffffffff);
    chk(out_pins[511:500], 12'hfff);
    run(IIO_OP_FMT_OUT, 9'h1e, 9'h0, 6'h0, 15'h0, 1'b1, 32'h0);
    chk({res_err_q, out_pins[37:30]}, 9'h15a);
  endtask
  task automatic t_latch;
    run(IIO_OP_LATCH_ON, 9'h2, 9'h5, 6'h1, 15'h0, 1'b1, 32'h0);
    chk(out_pins[5:2], 4'hf);
    run(IIO_OP_OUT, 9'h28, 9'h0, 6'h1, 15'h0, 1'b0, 32'h0);
    chk(out_image[5:2], 4'hf);
    run(IIO_OP_LATCH_OFF, 9'h5, 9'h12, 6'h1, 15'h0, 1'b1, 32'h0);
    chk(out_pins[18:2], 17'h7);
    run(IIO_OP_LATCH_ON, 9'h9, 9'h8, 6'h1, 15'h0, 1'b1, 32'h0);
    chk({res_err_q, out_pins[9:8]}, 3'h4);
  endtask
  task automatic t_load;
    settle({16'h3c5a, 480'h0, 16'ha5c3});
    run(IIO_OP_WORD_LOAD, 9'h0, 9'h0, 6'h1, 15'h4100, 1'b0, 32'hffffffff);
    chk(res_acc_q, 32'ha5c3);
    chk(res_acc_we_q, 1'b1);
    run(IIO_OP_WORD_LOAD, 9'h0, 9'h0, 6'h1, 15'h411f, 1'b0, 32'h0);
    chk(res_acc_q, 32'h3c5a);
    run(IIO_OP_WORD_LOAD, 9'h0, 9'h0, 6'h1, 15'h4120, 1'b0, 32'h0);
    chk(res_err_q, 1'b1);
    chk(res_acc_we_q, 1'b0);
    run(IIO_OP_WORD_LOAD, 9'h0, 9'h0, 6'h1, 15'h40ff, 1'b0, 32'h0);
    chk(res_err_q, 1'b1);
    run(IIO_OP_FIELD_LOAD, 9'h8, 9'h0, 6'h8, 15'h0, 1'b0, 32'hffffffff);
    chk(res_acc_q, 32'ha5);
    run(IIO_OP_FIELD_LOAD, 9'h1f0, 9'h0, 6'h20, 15'h0, 1'b0, 32'h0);
    chk(res_acc_q, 32'h3c5a);
    run(IIO_OP_FIELD_LOAD, 9'h8, 9'h0, 6'h21, 15'h0, 1'b0, 32'h0);
    chk(res_err_q, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    chk({cmd_ready, done, |out_pins}, 3'h4);
    t_inv();
    t_out();
    t_fmt();
    t_latch();
    t_load();
    stop_test();
  end
  // Watchdog: twenty-two requests of about three cycles each, with ample margin
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule // immediate_io_access_unit_bench
